// File: core/pcb_pkg.sv
// Constants and carrier types for the bridge configuration register slice
`default_nettype none
package pcb_pkg;
    localparam logic [7:0] IDX_HEADER_TYPE = 8'h0E;
    localparam logic [7:0] IDX_SELF_TEST   = 8'h0F;
    localparam logic [7:0] IDX_RSVD_LO     = 8'h10;
    localparam logic [7:0] IDX_RSVD_HI     = 8'h3F;
    localparam logic [7:0] IDX_FUNC_CTRL1  = 8'h40;

    localparam logic [7:0] RST_HEADER_TYPE = 8'h00;
    localparam logic [7:0] RST_SELF_TEST   = 8'h00;
    localparam logic [7:0] RST_FUNC_CTRL1  = 8'h79;
    localparam logic [7:0] READ_ZERO       = 8'h00;

    localparam int BIT_MULTI_FUNC   = 7;
    localparam int BIT_SINGLE_WRITE = 6;
    localparam int BIT_SINGLE_READ  = 5;
    localparam int BIT_RETRY_BUSY   = 4;

    // Configuration access from the PCI target front end
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] index;
        logic [7:0] data;
    } pcb_cfg_req_t;

    // Inbound target transaction events
    typedef struct packed {
        logic start;
        logic write;
        logic xfer;
        logic done;
        logic bufWaiting;
    } pcb_tgt_req_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_BURST = 3'b010,
        ST_DISC  = 3'b100
    } pcb_tgt_state_t;
endpackage : pcb_pkg
`default_nettype wire

// File: core/pcb_config_regs.sv
// Configuration register slice of the bridge and its target burst control
`default_nettype none
module pcb_config_regs
    import pcb_pkg::*;
#(
    parameter bit MULTI_FUNCTION = 1'b0
) (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire pcb_pkg::pcb_cfg_req_t cfgReq,
    input  wire pcb_pkg::pcb_tgt_req_t tgtReq,
    output logic [7:0]                 cfgRdData,
    output logic                       cfgRdValid,
    output logic                       tgtDisconnect,
    output logic                       tgtRetry,
    output logic [7:0]                 funcCtrl1
);
    import pcb_pkg::*;

    logic [7:0]     funcCtrl1_r;
    logic [7:0]     funcCtrl1_nxt;
    logic [7:0]     rdData_r;
    logic [7:0]     rdData_nxt;
    logic           rdValid_r;
    logic           rdValid_nxt;
    logic           disc_r;
    logic           disc_nxt;
    logic           retry_r;
    logic           retry_nxt;
    pcb_tgt_state_t state_r;
    pcb_tgt_state_t state_nxt;
    logic           singleBeat;

    // Read decode for every index of the slice; unmapped places fall to zero
    function automatic logic [7:0] readMux(input logic [7:0] idx, input logic [7:0] fc);
        logic [7:0] v;
        v = READ_ZERO;
        if (idx == IDX_HEADER_TYPE) begin
            v = RST_HEADER_TYPE;
            v[BIT_MULTI_FUNC] = MULTI_FUNCTION;
        end else if (idx == IDX_SELF_TEST) begin
            v = RST_SELF_TEST;
        end else if (idx >= IDX_RSVD_LO && idx <= IDX_RSVD_HI) begin
            v = READ_ZERO;
        end else if (idx == IDX_FUNC_CTRL1) begin
            v = fc;
        end
        return v;
    endfunction

    // Register write and read answer; only index 40h has storage, so RO and reserved writes fall away
    always_comb begin
        funcCtrl1_nxt = funcCtrl1_r;
        rdData_nxt    = rdData_r;
        rdValid_nxt   = 1'b0;
        if (cfgReq.wr && cfgReq.index == IDX_FUNC_CTRL1) begin
            funcCtrl1_nxt = cfgReq.data;
        end
        if (cfgReq.rd) begin
            rdData_nxt  = readMux(cfgReq.index, funcCtrl1_r);
            rdValid_nxt = 1'b1;
        end
    end

    // Bit 7 is stored as written; keeping it intact is software's job
    always_ff @(posedge clk) begin
        if (!resetn) begin
            funcCtrl1_r <= RST_FUNC_CTRL1;
            rdData_r    <= READ_ZERO;
            rdValid_r   <= 1'b0;
        end else begin
            funcCtrl1_r <= funcCtrl1_nxt;
            rdData_r    <= rdData_nxt;
            rdValid_r   <= rdValid_nxt;
        end
    end

    // Direction only matters in the start cycle; later changes are ignored
    assign singleBeat = tgtReq.write ? funcCtrl1_r[BIT_SINGLE_WRITE] : funcCtrl1_r[BIT_SINGLE_READ];

    // Target control: retry at start, else disconnect after first beat when single-beat
    always_comb begin
        state_nxt = state_r;
        disc_nxt  = disc_r;
        retry_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                disc_nxt = 1'b0;
                if (tgtReq.start) begin
                    if (funcCtrl1_r[BIT_RETRY_BUSY] && tgtReq.bufWaiting) begin
                        retry_nxt = 1'b1;
                    end else if (singleBeat) begin
                        state_nxt = ST_DISC;
                    end else begin
                        state_nxt = ST_BURST;
                    end
                end
            end
            ST_DISC: begin
                if (tgtReq.done) begin
                    state_nxt = ST_IDLE;
                    disc_nxt  = 1'b0;
                end else if (tgtReq.xfer) begin
                    disc_nxt = 1'b1;
                end
            end
            ST_BURST: begin
                if (tgtReq.done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                disc_nxt  = 1'b0;
            end
        endcase
    end

    // Target state and the two answer flops; retry is a one-cycle pulse
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            disc_r  <= 1'b0;
            retry_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            disc_r  <= disc_nxt;
            retry_r <= retry_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign cfgRdData     = rdData_r;
    assign cfgRdValid    = rdValid_r;
    assign tgtDisconnect = disc_r;
    assign tgtRetry      = retry_r;
    assign funcCtrl1     = funcCtrl1_r;

    // Register read and write checks; each read answers exactly one cycle later
    a_header_type_read: assert property (@(posedge clk) disable iff (!resetn)
        cfgReq.rd && cfgReq.index == IDX_HEADER_TYPE |=> cfgRdValid
        && cfgRdData[BIT_MULTI_FUNC-1:0] == RST_HEADER_TYPE[BIT_MULTI_FUNC-1:0])
        else $error("header type layout not zero");
    a_header_multi_bit: assert property (@(posedge clk) disable iff (!resetn)
        cfgReq.rd && cfgReq.index == IDX_HEADER_TYPE |=> cfgRdData[BIT_MULTI_FUNC] == MULTI_FUNCTION)
        else $error("multifunction bit wrong");
    a_self_test_zero: assert property (@(posedge clk) disable iff (!resetn)
        cfgReq.rd && cfgReq.index == IDX_SELF_TEST |=> cfgRdData == READ_ZERO)
        else $error("self-test register not zero");
    a_func_ctrl_reset: assert property (@(posedge clk)
        !resetn |=> funcCtrl1 == RST_FUNC_CTRL1)
        else $error("function control reset value wrong");
    a_func_ctrl_write: assert property (@(posedge clk) disable iff (!resetn)
        cfgReq.wr && cfgReq.index == IDX_FUNC_CTRL1 && !cfgReq.rd ##1 cfgReq.rd && cfgReq.index == IDX_FUNC_CTRL1
        |=> cfgRdData == $past(cfgReq.data, 2))
        else $error("function control write not read back");
    a_ro_write_ignored: assert property (@(posedge clk) disable iff (!resetn)
        cfgReq.wr && (cfgReq.index == IDX_HEADER_TYPE || cfgReq.index == IDX_SELF_TEST) |=> $stable(funcCtrl1))
        else $error("read-only write reached control one");
    a_rsvd_write_ignored: assert property (@(posedge clk) disable iff (!resetn)
        cfgReq.wr && cfgReq.index >= IDX_RSVD_LO && cfgReq.index <= IDX_RSVD_HI |=> $stable(funcCtrl1))
        else $error("reserved write reached control one");
    a_rd_valid_after: assert property (@(posedge clk) disable iff (!resetn)
        cfgReq.rd |=> cfgRdValid)
        else $error("read not answered");
    a_rd_valid_pulse: assert property (@(posedge clk) disable iff (!resetn)
        !cfgReq.rd |=> !cfgRdValid)
        else $error("read valid without read");
    a_rd_data_holds: assert property (@(posedge clk) disable iff (!resetn)
        !cfgReq.rd |=> $stable(cfgRdData))
        else $error("read data moved without read");

    // Target control checks and the reserved read check
    // Start is only taken in idle, so the start and burst checks pin the state as well
    a_single_write_disc: assert property (@(posedge clk) disable iff (!resetn)
        state_r == ST_IDLE && tgtReq.start && tgtReq.write && funcCtrl1[BIT_SINGLE_WRITE] && !tgtRetry
        && !(funcCtrl1[BIT_RETRY_BUSY] && tgtReq.bufWaiting) ##1 tgtReq.xfer && !tgtReq.done |=> tgtDisconnect)
        else $error("single write did not disconnect");
    a_burst_no_disc: assert property (@(posedge clk) disable iff (!resetn)
        state_r == ST_BURST |-> !tgtDisconnect)
        else $error("burst disconnected");
    a_retry_when_busy: assert property (@(posedge clk) disable iff (!resetn)
        tgtRetry |-> $past(funcCtrl1[BIT_RETRY_BUSY]) && $past(tgtReq.bufWaiting) && $past(tgtReq.start))
        else $error("retry without cause");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
        cfgReq.rd && cfgReq.index >= IDX_RSVD_LO && cfgReq.index <= IDX_RSVD_HI |=> cfgRdData == READ_ZERO)
        else $error("reserved index not zero");

    // Burst, retry and disconnect checks driven from the control bits, with the start checks pinned to idle
    a_single_read_disc: assert property (@(posedge clk) disable iff (!resetn)
        state_r == ST_IDLE && tgtReq.start && !tgtReq.write && funcCtrl1[BIT_SINGLE_READ]
        && !(funcCtrl1[BIT_RETRY_BUSY] && tgtReq.bufWaiting) ##1 tgtReq.xfer && !tgtReq.done |=> tgtDisconnect)
        else $error("single read did not disconnect");
    a_burst_write_open: assert property (@(posedge clk) disable iff (!resetn)
        state_r == ST_IDLE && tgtReq.start && tgtReq.write && !funcCtrl1[BIT_SINGLE_WRITE]
        && !(funcCtrl1[BIT_RETRY_BUSY] && tgtReq.bufWaiting) ##1 tgtReq.xfer |=> !tgtDisconnect)
        else $error("burst write disconnected");
    a_burst_read_open: assert property (@(posedge clk) disable iff (!resetn)
        state_r == ST_IDLE && tgtReq.start && !tgtReq.write && !funcCtrl1[BIT_SINGLE_READ]
        && !(funcCtrl1[BIT_RETRY_BUSY] && tgtReq.bufWaiting) ##1 tgtReq.xfer |=> !tgtDisconnect)
        else $error("burst read disconnected");
    a_retry_on_busy: assert property (@(posedge clk) disable iff (!resetn)
        state_r == ST_IDLE && tgtReq.start && funcCtrl1[BIT_RETRY_BUSY] && tgtReq.bufWaiting |=> tgtRetry)
        else $error("busy start not retried");
    a_retry_off: assert property (@(posedge clk) disable iff (!resetn)
        !funcCtrl1[BIT_RETRY_BUSY] |=> !tgtRetry)
        else $error("retry while retry disabled");
    a_disc_after_done: assert property (@(posedge clk) disable iff (!resetn)
        tgtReq.done |=> !tgtDisconnect)
        else $error("disconnect outlived transaction");
endmodule // pcb_config_regs
`default_nettype wire

// File: dv/pcb_host.sv
// Behavioural PCI initiator for config and target traffic
`default_nettype none
module pcb_host
    import pcb_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic [7:0]            cfgRdData,
    input  wire logic                  cfgRdValid,
    input  wire logic                  tgtDisconnect,
    input  wire logic                  tgtRetry,
    output var  pcb_pkg::pcb_cfg_req_t cfgReq,
    output var  pcb_pkg::pcb_tgt_req_t tgtReq
);
    timeunit 1ns;
    timeprecision 1ns;
    import pcb_pkg::*;
    // Released fields flip so stale values never pose as requests
    initial {cfgReq, tgtReq} = '0;
    task automatic cfg_read(input logic [7:0] idx, output logic [8:0] r);
        @(negedge clk) cfgReq = '{1'b1, 1'b0, idx, ~cfgReq.data};
        @(negedge clk) cfgReq = '{1'b0, 1'b0, ~idx, ~cfgReq.data};
        r = {cfgRdValid, cfgRdData};
    endtask
    // Read-modify-write, as the top bit of control one is not ours
    task automatic cfg_write(input logic [7:0] idx, input logic [7:0] d);
        logic [8:0] r;
        r = {1'b0, d};
        if (idx == IDX_FUNC_CTRL1) cfg_read(idx, r);
        @(negedge clk) cfgReq = '{1'b0, 1'b1, idx, {r[7], d[6:0]}};
        cfg_read(idx, r); // Back-to-back readback, as a careful driver confirms
    endtask
    task automatic tgt_txn(input logic w, input logic b, output logic [2:0] s);
        @(negedge clk) tgtReq = '{1'b1, w, 1'b0, 1'b0, b};
        @(negedge clk) tgtReq = '{1'b0, ~w, 1'b1, 1'b0, ~b};
        s[2] = tgtRetry;
        @(negedge clk) tgtReq = '{1'b0, ~w, 1'b0, 1'b1, ~b};
        s[1] = tgtDisconnect;
        @(negedge clk) tgtReq = '{1'b0, ~w, 1'b0, 1'b0, ~b};
        s[0] = tgtDisconnect | tgtRetry;
    endtask
endmodule // pcb_host
`default_nettype wire

// File: dv/pcb_config_regs_tb_top.sv
// Bench for the config register slice
`default_nettype none
module pcb_config_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pcb_pkg::*;
    logic         clk = 1'b0, resetn = 1'b0, cfgRdValid, tgtDisconnect, tgtRetry;
    logic [7:0]   cfgRdData, funcCtrl1;
    pcb_cfg_req_t cfgReq;
    pcb_tgt_req_t tgtReq;
    int           n_mismatch = 0, checks_done = 0;
    logic [7:0]   idxs [4] = '{IDX_HEADER_TYPE, IDX_SELF_TEST, IDX_RSVD_LO, IDX_RSVD_HI};
    // 20 MHz clock
    always #25 clk = ~clk;
    pcb_config_regs pcb_config_regs_inst (.clk(clk), .resetn(resetn), .cfgReq(cfgReq), .tgtReq(tgtReq),
        .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .tgtDisconnect(tgtDisconnect), .tgtRetry(tgtRetry),
        .funcCtrl1(funcCtrl1));
    pcb_host pcb_host_inst (.clk(clk), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
        .tgtDisconnect(tgtDisconnect), .tgtRetry(tgtRetry), .cfgReq(cfgReq), .tgtReq(tgtReq));
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        n_mismatch += int'(got !== exp);
        if (got !== exp) $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [8:0] r;
        pcb_host_inst.cfg_read(idx, r);
        chk(r, {1'b1, exp});
    endtask
    task automatic tgt_chk(input logic [3:0] m);
        logic [2:0] s;
        pcb_host_inst.tgt_txn(m[3], m[2], s);
        chk({6'h00, s}, {6'h00, m[0], m[1], 1'b0}); // Retry, then disconnect up to done
    endtask
    // Read-only and reserved places ignore writes
    task automatic test_registers();
        rd_chk(IDX_FUNC_CTRL1, 8'h79);
        foreach (idxs[i]) pcb_host_inst.cfg_write(idxs[i], 8'hA5);
        foreach (idxs[i]) rd_chk(idxs[i], 8'h00);
        pcb_host_inst.cfg_write(IDX_FUNC_CTRL1, 8'hFF);
        rd_chk(IDX_FUNC_CTRL1, 8'h7F);
        chk({1'b0, funcCtrl1}, 9'h07F);
    endtask
    // Mode bits on and off; retry beats single-beat
    task automatic test_target();
        tgt_chk(4'hA);
        tgt_chk(4'h2);
        tgt_chk(4'h5);
        pcb_host_inst.cfg_write(IDX_FUNC_CTRL1, 8'h40);
        tgt_chk(4'hE);
        tgt_chk(4'h0);
        pcb_host_inst.cfg_write(IDX_FUNC_CTRL1, 8'h20);
        tgt_chk(4'h8);
        tgt_chk(4'h2);
    endtask
    // Reset in mid-run brings control one back to its default
    task automatic test_reset();
        @(negedge clk) resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        chk({1'b0, funcCtrl1}, 9'h079);
        rd_chk(IDX_FUNC_CTRL1, 8'h79);
    endtask
    initial begin
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        test_registers();
        test_target();
        test_reset();
        end_of_test();
    end
    // Traffic takes about 82 cycles; 2000 means stuck
    initial begin
        #100000 n_mismatch++;
        end_of_test();
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
endmodule // pcb_config_regs_tb_top
`default_nettype wire
